/* File: adc_consts.svh */
// Functional notes
// - Writing start bit 1 begins selected conversion.
// - Writing start bit 0 stops, returns idle.
// - Single mode clears start bit after conversion.
// - Scan repeats until software, reset, standby, stop.
// - Mode bit: 0 single, 1 scan, resets 0.
// - Single codes 0000-0111 pick inputs 0-7.
// - Scan codes run group base up to code.
// - End flag per pass; interrupt when enabled.
// - Results left-justified bits 6-15, per position.
// - Codes 10xx are group 2; 11xx prohibited.
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define ADC_OFFSET_CSR 8'h00
`define ADC_OFFSET_RESULT_A 8'h04
`define ADC_OFFSET_RESULT_B 8'h08
`define ADC_OFFSET_RESULT_C 8'h0C
`define ADC_OFFSET_RESULT_D 8'h10
`define ADC_OFFSET_EVT_STATUS 8'h14
`define ADC_OFFSET_EVT_CLEAR 8'h18
`define ADC_OFFSET_EVT_ENABLE 8'h1C

// Field positions inside the control and status register.
`define ADC_CSR_END_FLAG_BIT 7
`define ADC_CSR_IRQ_ENABLE_BIT 6
`define ADC_CSR_START_BIT 5
`define ADC_CSR_SCAN_BIT 4
`define ADC_CSR_CHANNEL_MSB 3
`define ADC_CSR_CHANNEL_LSB 0

// Result layout: the converted value starts at this bit.
`define ADC_RESULT_LSB 6

// Reset values.
`define ADC_CSR_RESET 8'h00
`define ADC_CHANNEL_RESET 4'h0
`define ADC_RESULT_RESET 10'h000

// Event status bit positions and count.
`define ADC_EVENT_PASS_END 0
`define ADC_EVENT_ABORT 1
`define ADC_EVENT_COUNT 2

// Bus responses.
`define ADC_RESP_OKAY 2'h0
`define ADC_RESP_DECERR 2'h3

`endif

/* File: adc_pkg.sv */
package adc_pkg;

    // Sequencer states, one-hot.
    typedef enum logic [2:0] {
        ENGINE_IDLE = 3'h1,
        ENGINE_REQUEST = 3'h2,
        ENGINE_ADVANCE = 3'h4
    } engine_state_e;

endpackage

/* File: adc_channel_plan.sv */
`timescale 1ns/1ps
`default_nettype none

// Turns a channel code and a mode into the first and last channel of
// the run; both high bits set marks the code as unusable.
module adc_channel_plan (
    input wire logic [3:0] channel_code,
    input wire logic scan_mode,
    output logic [3:0] first_channel,
    output logic [3:0] last_channel,
    output logic prohibited
);

    // Scan starts at the group base; single starts at the code itself.
    always_comb begin
        if (scan_mode) begin
            first_channel = {channel_code[3:2], 2'h0};
        end else begin
            first_channel = channel_code;
        end
        last_channel = channel_code;
        prohibited = channel_code[3] && channel_code[2];
    end

endmodule

`default_nettype wire

/* File: adc_event_status.sv */
`timescale 1ns/1ps
`default_nettype none

// Sticky event bits with a write-one-to-clear port and an enable mask.
module adc_event_status #(
    parameter int EVENT_COUNT = 2
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [EVENT_COUNT-1:0] event_pulse,
    input wire logic clear_write,
    input wire logic [EVENT_COUNT-1:0] clear_data,
    input wire logic enable_write,
    input wire logic [EVENT_COUNT-1:0] enable_data,
    output logic [EVENT_COUNT-1:0] status,
    output logic [EVENT_COUNT-1:0] enable,
    output logic irq
);

    // Refuse a width the register layout cannot hold.
    if (EVENT_COUNT < 1 || EVENT_COUNT > 32) begin : g_bad_count
        $error("EVENT_COUNT must lie between 1 and 32.");
    end

    genvar i;
    for (i = 0; i < EVENT_COUNT; i++) begin : g_bit
        // A new event in the clearing cycle keeps the bit set.
        always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
                status[i] <= 1'b0;
            end else if (event_pulse[i]) begin
                status[i] <= 1'b1;
            end else if (clear_write && clear_data[i]) begin
                status[i] <= 1'b0;
            end
        end

        // Enable mask bit.
        always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
                enable[i] <= 1'b0;
            end else if (enable_write) begin
                enable[i] <= enable_data[i];
            end
        end
    end

    // Level request while any enabled bit is set.
    assign irq = |(status & enable);

endmodule

`default_nettype wire

/* File: adc_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_consts.svh"

// Converter sequencer: control/status register, four result registers,
// a channel run engine that drives an external converter, and event
// interrupts, all behind an AXI4-Lite slave.
module adc_sequencer #(
    parameter int RESULT_WIDTH = 10
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic standby_entry,
    input wire logic module_stop,
    output logic conversion_request,
    output logic [3:0] conversion_channel,
    input wire logic conversion_done,
    input wire logic [RESULT_WIDTH-1:0] conversion_result,
    output logic interrupt_request
);

    // The result must fit above the fixed low zero bits of a half word.
    if (RESULT_WIDTH != 16 - `ADC_RESULT_LSB) begin : g_bad_width
        $error("RESULT_WIDTH must fill bits 6 to 15 of the result.");
    end

    // Write address and data held until both halves have arrived.
    logic aw_held;
    logic [7:0] aw_addr_held;
    logic w_held;
    logic [31:0] w_data_held;
    logic [3:0] w_strb_held;
    logic write_fire;

    // Control and status fields.
    logic end_flag;
    logic end_flag_armed;
    logic end_irq_enable;
    logic start_bit;
    logic scan_mode;
    logic [3:0] channel_select;
    logic [7:0] csr_value;

    // Latched run plan and engine state.
    adc_pkg::engine_state_e state;
    adc_pkg::engine_state_e next_state;
    logic [3:0] run_first;
    logic [3:0] run_last;
    logic run_scan;
    logic [3:0] plan_first;
    logic [3:0] plan_last;
    logic plan_prohibited;

    // One entry per position inside a group of four inputs.
    logic [RESULT_WIDTH-1:0] result_store [4];

    // Decoded strobes and engine events.
    logic write_csr;
    logic write_evt_clear;
    logic write_evt_enable;
    logic write_mapped;
    logic read_fire;
    logic read_mapped;
    logic [31:0] read_value;
    logic start_request;
    logic stop_request;
    logic force_stop;
    logic start_accept;
    logic abort_run;
    logic channel_finish;
    logic pass_end;
    logic single_finish;
    logic [`ADC_EVENT_COUNT-1:0] event_pulse;
    logic [`ADC_EVENT_COUNT-1:0] event_status;
    logic [`ADC_EVENT_COUNT-1:0] event_enable;
    logic event_irq;

    // A half is taken only while no response is pending, so a second
    // write cannot overrun the first.
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign write_fire = aw_held && w_held && !bvalid;

    // Capture the write address.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            aw_held <= 1'b0;
            aw_addr_held <= 8'h00;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr_held <= awaddr;
        end else if (write_fire) begin
            aw_held <= 1'b0;
        end
    end

    // Capture the write data and strobes.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            w_held <= 1'b0;
            w_data_held <= 32'h0000_0000;
            w_strb_held <= 4'h0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data_held <= wdata;
            w_strb_held <= wstrb;
        end else if (write_fire) begin
            w_held <= 1'b0;
        end
    end

    // Write address decode; only the low byte lane carries the fields.
    always_comb begin
        write_csr = 1'b0;
        write_evt_clear = 1'b0;
        write_evt_enable = 1'b0;
        write_mapped = 1'b1;
        if (aw_addr_held == `ADC_OFFSET_CSR) begin
            write_csr = write_fire && w_strb_held[0];
        end else if (aw_addr_held == `ADC_OFFSET_RESULT_A ||
                     aw_addr_held == `ADC_OFFSET_RESULT_B ||
                     aw_addr_held == `ADC_OFFSET_RESULT_C ||
                     aw_addr_held == `ADC_OFFSET_RESULT_D ||
                     aw_addr_held == `ADC_OFFSET_EVT_STATUS) begin
            // Read-only registers accept and ignore writes.
            write_mapped = 1'b1;
        end else if (aw_addr_held == `ADC_OFFSET_EVT_CLEAR) begin
            write_evt_clear = write_fire && w_strb_held[0];
        end else if (aw_addr_held == `ADC_OFFSET_EVT_ENABLE) begin
            write_evt_enable = write_fire && w_strb_held[0];
        end else begin
            write_mapped = 1'b0;
        end
    end

    // Write response, one cycle after both halves are present.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bvalid <= 1'b0;
            bresp <= `ADC_RESP_OKAY;
        end else if (write_fire) begin
            bvalid <= 1'b1;
            bresp <= write_mapped ? `ADC_RESP_OKAY : `ADC_RESP_DECERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Assemble the control and status byte from its fields.
    always_comb begin
        csr_value = `ADC_CSR_RESET;
        csr_value[`ADC_CSR_END_FLAG_BIT] = end_flag;
        csr_value[`ADC_CSR_IRQ_ENABLE_BIT] = end_irq_enable;
        csr_value[`ADC_CSR_START_BIT] = start_bit;
        csr_value[`ADC_CSR_SCAN_BIT] = scan_mode;
        csr_value[`ADC_CSR_CHANNEL_MSB:`ADC_CSR_CHANNEL_LSB] =
            channel_select;
    end

    // Read address decode; results are left-justified, low bits zero.
    always_comb begin
        read_value = 32'h0000_0000;
        read_mapped = 1'b1;
        if (araddr == `ADC_OFFSET_CSR) begin
            read_value[7:0] = csr_value;
        end else if (araddr == `ADC_OFFSET_RESULT_A) begin
            read_value[15:`ADC_RESULT_LSB] = result_store[0];
        end else if (araddr == `ADC_OFFSET_RESULT_B) begin
            read_value[15:`ADC_RESULT_LSB] = result_store[1];
        end else if (araddr == `ADC_OFFSET_RESULT_C) begin
            read_value[15:`ADC_RESULT_LSB] = result_store[2];
        end else if (araddr == `ADC_OFFSET_RESULT_D) begin
            read_value[15:`ADC_RESULT_LSB] = result_store[3];
        end else if (araddr == `ADC_OFFSET_EVT_STATUS) begin
            read_value[`ADC_EVENT_COUNT-1:0] = event_status;
        end else if (araddr == `ADC_OFFSET_EVT_CLEAR) begin
            // The clear register is write-only and reads as zero.
            read_value = 32'h0000_0000;
        end else if (araddr == `ADC_OFFSET_EVT_ENABLE) begin
            read_value[`ADC_EVENT_COUNT-1:0] = event_enable;
        end else begin
            read_mapped = 1'b0;
        end
    end

    // A read is taken only while no read answer is pending.
    assign arready = !rvalid;
    assign read_fire = arvalid && arready;

    // Read answer, registered one cycle after the address is taken.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `ADC_RESP_OKAY;
        end else if (read_fire) begin
            rvalid <= 1'b1;
            rdata <= read_value;
            rresp <= read_mapped ? `ADC_RESP_OKAY : `ADC_RESP_DECERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Start and stop requests carried by a write of the control byte.
    assign start_request = write_csr && w_data_held[`ADC_CSR_START_BIT];
    assign stop_request = write_csr && !w_data_held[`ADC_CSR_START_BIT];
    assign force_stop = standby_entry || module_stop;

    // The plan is judged on the code that the same write carries, so a
    // single write can select a channel and start it.
    adc_channel_plan u_plan (
        .channel_code(w_data_held[`ADC_CSR_CHANNEL_MSB:
                                  `ADC_CSR_CHANNEL_LSB]),
        .scan_mode(w_data_held[`ADC_CSR_SCAN_BIT]),
        .first_channel(plan_first),
        .last_channel(plan_last),
        .prohibited(plan_prohibited)
    );

    // A prohibited code never starts; a running start is left alone.
    assign start_accept = start_request && !start_bit && !force_stop &&
                          !plan_prohibited;
    assign abort_run = start_bit && (stop_request || force_stop);
    assign channel_finish = (state == adc_pkg::ENGINE_REQUEST) &&
                            conversion_done && !abort_run;
    assign pass_end = channel_finish && (conversion_channel == run_last);
    assign single_finish = pass_end && !run_scan;

    // Mode and channel are frozen while a run is active, so a careless
    // write can never bend a sequence half way through.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            scan_mode <= 1'b0;
            channel_select <= `ADC_CHANNEL_RESET;
        end else if (write_csr && !start_bit) begin
            scan_mode <= w_data_held[`ADC_CSR_SCAN_BIT];
            channel_select <=
                w_data_held[`ADC_CSR_CHANNEL_MSB:`ADC_CSR_CHANNEL_LSB];
        end
    end

    // End-of-conversion interrupt enable.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            end_irq_enable <= 1'b0;
        end else if (write_csr) begin
            end_irq_enable <= w_data_held[`ADC_CSR_IRQ_ENABLE_BIT];
        end
    end

    // Start bit: stops win over a start, and single mode ends itself.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            start_bit <= 1'b0;
        end else if (abort_run || force_stop) begin
            start_bit <= 1'b0;
        end else if (single_finish) begin
            start_bit <= 1'b0;
        end else if (start_accept) begin
            start_bit <= 1'b1;
        end
    end

    // The end flag may be cleared only by writing 0 after reading it as
    // 1; a pass that ends in the clearing cycle keeps it set.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            end_flag <= 1'b0;
            end_flag_armed <= 1'b0;
        end else if (pass_end) begin
            end_flag <= 1'b1;
        end else if (write_csr && end_flag_armed &&
                     !w_data_held[`ADC_CSR_END_FLAG_BIT]) begin
            end_flag <= 1'b0;
            end_flag_armed <= 1'b0;
        end else if (read_fire && araddr == `ADC_OFFSET_CSR &&
                     end_flag) begin
            end_flag_armed <= 1'b1;
        end
    end

    // Engine next state: request a channel, wait for the converter,
    // then step through one gap cycle before the next request.
    always_comb begin
        next_state = state;
        case (state)
            adc_pkg::ENGINE_IDLE: begin
                if (start_accept) begin
                    next_state = adc_pkg::ENGINE_REQUEST;
                end
            end
            adc_pkg::ENGINE_REQUEST: begin
                if (abort_run) begin
                    next_state = adc_pkg::ENGINE_IDLE;
                end else if (single_finish) begin
                    next_state = adc_pkg::ENGINE_IDLE;
                end else if (channel_finish) begin
                    next_state = adc_pkg::ENGINE_ADVANCE;
                end
            end
            adc_pkg::ENGINE_ADVANCE: begin
                if (abort_run) begin
                    next_state = adc_pkg::ENGINE_IDLE;
                end else begin
                    next_state = adc_pkg::ENGINE_REQUEST;
                end
            end
            default: begin
                next_state = adc_pkg::ENGINE_IDLE;
            end
        endcase
    end

    // Engine state and the request level seen by the converter.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= adc_pkg::ENGINE_IDLE;
            conversion_request <= 1'b0;
        end else begin
            state <= next_state;
            conversion_request <= (next_state == adc_pkg::ENGINE_REQUEST);
        end
    end

    // Run plan latched at the start; the channel steps and wraps.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            run_first <= `ADC_CHANNEL_RESET;
            run_last <= `ADC_CHANNEL_RESET;
            run_scan <= 1'b0;
            conversion_channel <= `ADC_CHANNEL_RESET;
        end else if (start_accept) begin
            run_first <= plan_first;
            run_last <= plan_last;
            run_scan <= w_data_held[`ADC_CSR_SCAN_BIT];
            conversion_channel <= plan_first;
        end else if (pass_end && run_scan) begin
            conversion_channel <= run_first;
        end else if (channel_finish && !pass_end) begin
            conversion_channel <= conversion_channel + 4'h1;
        end
    end

    // Each result lands in the register of its position in the group.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (int k = 0; k < 4; k++) begin
                result_store[k] <= `ADC_RESULT_RESET;
            end
        end else if (channel_finish) begin
            result_store[conversion_channel[1:0]] <=
                conversion_result;
        end
    end

    // Pass ends and aborted runs feed the sticky event register.
    assign event_pulse[`ADC_EVENT_PASS_END] = pass_end;
    assign event_pulse[`ADC_EVENT_ABORT] = abort_run &&
        (state != adc_pkg::ENGINE_IDLE);

    adc_event_status #(
        .EVENT_COUNT(`ADC_EVENT_COUNT)
    ) u_events (
        .clk_sys(clk_sys),
        .reset(reset),
        .event_pulse(event_pulse),
        .clear_write(write_evt_clear),
        .clear_data(w_data_held[`ADC_EVENT_COUNT-1:0]),
        .enable_write(write_evt_enable),
        .enable_data(w_data_held[`ADC_EVENT_COUNT-1:0]),
        .status(event_status),
        .enable(event_enable),
        .irq(event_irq)
    );

    // One interrupt line: the end flag when enabled, or any enabled event.
    assign interrupt_request = (end_flag && end_irq_enable) ||
                               event_irq;

endmodule

`default_nettype wire

/* File: adc_sequencer_chk.sv */
`timescale 1ns/1ps
`default_nettype none

// Port-level watcher for the sequencer's bus handshakes and converter link.
module adc_sequencer_chk (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic standby_entry,
    input wire logic module_stop,
    input wire logic conversion_request,
    input wire logic [3:0] conversion_channel,
    input wire logic conversion_done
);
    // One clock domain, so clock and reset are given once here.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // A finished channel must let go of the converter for a cycle.
    a_done_drops_req: assert property (
        conversion_request && conversion_done |=> !conversion_request)
        else $error("request held after done");
    // The last group is never handed to the converter.
    a_no_prohibited: assert property (
        conversion_request |-> conversion_channel[3:2] != 2'h3)
        else $error("prohibited channel requested");
    // The channel may not move under a pending conversion.
    a_channel_frozen: assert property (
        conversion_request && !conversion_done
        |=> !conversion_request || $stable(conversion_channel))
        else $error("channel moved during request");
    // Standby entry ends any run at once.
    a_standby_halts: assert property (
        standby_entry |=> !conversion_request)
        else $error("request survived standby");
    // Module stop ends any run at once.
    a_stop_halts: assert property (
        module_stop |=> !conversion_request)
        else $error("request survived module stop");
    // A taken read is answered on the very next cycle.
    a_read_answer: assert property (
        arvalid && arready |=> rvalid)
        else $error("read answer late");
    // No new read is accepted while an answer is outstanding.
    a_read_refused: assert property (
        rvalid |-> !arready)
        else $error("read taken while answering");
    // No write half is accepted while a response is outstanding.
    a_write_refused: assert property (
        bvalid |-> !awready && !wready)
        else $error("write taken while responding");
endmodule

`default_nettype wire

/* File: adc_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_consts.svh"

// Register-level bench: bus tasks plus a stand-in converter.
module adc_sequencer_test;
    // Protection and strobes are tied; only the low byte matters.
    logic clk_sys = 1'b0, reset = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic standby_entry = 1'b0, module_stop = 1'b0;
    logic conversion_done = 1'b0;
    logic [9:0] conversion_result = 10'h000;
    logic awready, wready, bvalid, arready, rvalid;
    logic conversion_request, interrupt_request;
    logic [1:0] bresp, rresp, rd_resp, wr_resp;
    logic [31:0] rdata, rd_data;
    logic [3:0] conversion_channel;
    int n_errors = 0, comparisons = 0;

    adc_sequencer #(.RESULT_WIDTH(10)) u_dut (
        .clk_sys(clk_sys), .reset(reset), .awaddr(awaddr),
        .awprot(awprot), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready),
        .standby_entry(standby_entry), .module_stop(module_stop),
        .conversion_request(conversion_request),
        .conversion_channel(conversion_channel),
        .conversion_done(conversion_done),
        .conversion_result(conversion_result),
        .interrupt_request(interrupt_request)
    );

    // Free-running system clock, 40 ns period.
    always #20 clk_sys = ~clk_sys;

    // Compares one value and counts the outcome.
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Write: both halves offered together, each dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        wr_resp = bresp;
        bready <= 1'b0;
    endtask

    // Read: address held until taken, data taken with rvalid.
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
    endtask

    // Stand-in converter: waits for a request, answers with one pulse.
    task automatic conv(input logic [3:0] ch, input logic [9:0] res);
        @(posedge clk_sys);
        while (!conversion_request) @(posedge clk_sys);
        chk("channel", 32'(conversion_channel), 32'(ch));
        conversion_result <= res;
        conversion_done <= 1'b1;
        @(posedge clk_sys);
        conversion_done <= 1'b0;
    endtask

    // Single place where the run ends, from the tests or the watchdog.
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The whole sequence needs a few hundred cycles; allow 20000, far more.
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        stop_test;
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        rd(`ADC_OFFSET_CSR);
        chk("csr reset", rd_data, 32'h00);
        rd(8'h20);
        chk("unmapped read", 32'(rd_resp), 32'(`ADC_RESP_DECERR));
        wr(8'h20, 32'h0);
        chk("unmapped write", 32'(wr_resp), 32'(`ADC_RESP_DECERR));
        $display("test registers done");
        // Every usable code in single mode, with the end interrupt on.
        for (int c = 0; c < 12; c++) begin
            wr(`ADC_OFFSET_CSR, 32'h60 | c);
            conv(4'(c), 10'h155 ^ 10'(c));
            rd(`ADC_OFFSET_CSR);
            chk("single csr", rd_data, 32'hC0 | c);
            chk("end irq", 32'(interrupt_request), 32'h1);
            rd(`ADC_OFFSET_RESULT_A + 8'(4 * (c % 4)));
            chk("result", rd_data, 32'(10'h155 ^ 10'(c)) << 6);
            wr(`ADC_OFFSET_CSR, 32'h00);
            chk("irq off", 32'(interrupt_request), 32'h0);
        end
        wr(`ADC_OFFSET_CSR, 32'h2C);
        rd(`ADC_OFFSET_CSR);
        chk("prohibited csr", rd_data, 32'h0C);
        chk("prohibited req", 32'(conversion_request), 32'h0);
        $display("test single done");
        // Scan 4..6, wrap once, then stop from software mid-run.
        // Old pass events from the single runs would hide the new one.
        wr(`ADC_OFFSET_EVT_CLEAR, 32'h3);
        wr(`ADC_OFFSET_EVT_ENABLE, 32'h1);
        chk("idle irq", 32'(interrupt_request), 32'h0);
        wr(`ADC_OFFSET_CSR, 32'h36);
        for (int c = 4; c < 7; c++) conv(4'(c), 10'h2AA);
        rd(`ADC_OFFSET_CSR);
        chk("scan csr", rd_data, 32'hB6);
        chk("pass irq", 32'(interrupt_request), 32'h1);
        wr(`ADC_OFFSET_EVT_CLEAR, 32'h1);
        chk("pass cleared", 32'(interrupt_request), 32'h0);
        conv(4'h4, 10'h2AA);
        wr(`ADC_OFFSET_CSR, 32'h00);
        rd(`ADC_OFFSET_EVT_STATUS);
        chk("abort event", rd_data, 32'h2);
        chk("stopped req", 32'(conversion_request), 32'h0);
        chk("masked irq", 32'(interrupt_request), 32'h0);
        rd(`ADC_OFFSET_CSR);
        chk("stopped csr", rd_data, 32'h16);
        wr(`ADC_OFFSET_EVT_CLEAR, 32'h3);
        $display("test scan done");
        // Standby, then module stop, each while a channel is pending.
        for (int k = 0; k < 2; k++) begin
            wr(`ADC_OFFSET_CSR, 32'h21);
            @(posedge clk_sys);
            standby_entry <= (k == 0);
            module_stop <= (k == 1);
            @(posedge clk_sys);
            standby_entry <= 1'b0;
            module_stop <= 1'b0;
            @(posedge clk_sys);
            chk("halt req", 32'(conversion_request), 32'h0);
            rd(`ADC_OFFSET_CSR);
            chk("halt csr", rd_data, 32'h01);
        end
        $display("test halt done");
        stop_test;
    end
endmodule

bind adc_sequencer adc_sequencer_chk u_chk (
    .clk_sys(clk_sys), .reset(reset), .awready(awready),
    .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .standby_entry(standby_entry),
    .module_stop(module_stop), .conversion_request(conversion_request),
    .conversion_channel(conversion_channel),
    .conversion_done(conversion_done)
);

`default_nettype wire
